// [verilog/ddr3_cmd_pkg.sv]
// constants and types shared by the command decoder and its beat buffer
package ddr3_cmd_pkg;
    localparam int NUM_BANKS = 8;
    localparam int BA_W      = 3;
    localparam int ROW_W     = 13;
    localparam int COL_W     = 10;
    localparam int DQ_W      = 16;
    localparam int DM_W      = 2;
    localparam int MR_CNT    = 4;
    localparam int MR_SEL_W  = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int BEAT_W    = BA_W + ROW_W + COL_W + DM_W + DQ_W;
    localparam int IN_W      = 6 + BA_W + ROW_W + DM_W + DQ_W;
    // address bit positions on column commands
    localparam int AP_BIT    = 10;
    localparam int BC_BIT    = 12;
    // mode register 0 field positions
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF    = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    localparam logic [3:0] BEATS_BL8 = 4'h8;
    localparam logic [3:0] BEATS_BC4 = 4'h4;
    localparam logic [ROW_W-1:0] MR_RESET = 13'h0000;
    // {ras_n, cas_n, we_n} with cs_n low
    localparam logic [2:0] OP_MRS = 3'h0;
    localparam logic [2:0] OP_REF = 3'h1;
    localparam logic [2:0] OP_PRE = 3'h2;
    localparam logic [2:0] OP_ACT = 3'h3;
    localparam logic [2:0] OP_WR  = 3'h4;
    localparam logic [2:0] OP_RD  = 3'h5;
    localparam logic [2:0] OP_ZQ  = 3'h6;
    localparam logic [2:0] OP_NOP = 3'h7;

    typedef enum logic [1:0] {
        PWR_ACTIVE, PWR_DOWN, PWR_SELF_REFRESH
    } pwr_t;

    typedef enum logic [3:0] {
        CMD_NONE, CMD_ACT, CMD_PRE, CMD_PREA, CMD_WR, CMD_RD, CMD_MRS,
        CMD_REF, CMD_SRE, CMD_SRX, CMD_PDE, CMD_PDX, CMD_ZQL, CMD_ZQS
    } cmd_t;
endpackage

// [verilog/ddr3_command_decoder.sv]
// command decoder, bank tracker, burst engine and write beat buffer
// What this block does
// - eight banks, each tracks one open row
// - activate opens row from address on an idle bank
// - precharge closes one bank, or all when a10 is high
// - write with both cke high starts a burst on an open bank
// - read with both cke high starts a burst on an open bank
// - column address of the command is the first burst column
// - a10 high on read or write closes the bank after the burst
// - on-the-fly mode: a12 low chops to four beats, else ignored
// - eight or four beats follow programmed sequential or interleave order
// - one beat per half link clock, four clocks per eight-beat access, two when chopped to four
// - mode register set while idle, bank address picks the register
// - inputs that a command does not use are ignored
// - refresh, self-refresh entry with cke low, exit on cke rise
// - cke falling with nop or deselect enters power-down
// - cke rising with nop or deselect leaves power-down or self-refresh
// - commands decode from current and previous cke samples
// - idle or active checks for activate, read and write use the addressed bank
// - write data masked where its mask pin is high
// - each mask pin gates only its own byte lane
`timescale 1ns/1ps

module beat_fifo #(
    parameter int WIDTH = ddr3_cmd_pkg::BEAT_W,
    parameter int DEPTH = ddr3_cmd_pkg::FIFO_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic          in_ready;
        logic          out_valid;
    } fst_t;
    localparam fst_t F_RST = '{wp: '0, rp: '0, cnt: '0,
                               in_ready: 1'b1, out_valid: 1'b0};
    fst_t             f;
    fst_t             next_f;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign push = in_valid && f.in_ready;
    assign pop  = f.out_valid && out_ready;

    always_comb begin
        next_f = f;
        if (push) begin
            next_f.wp = (f.wp == AW'(DEPTH - 1)) ? '0 : f.wp + 1'b1;
        end
        if (pop) begin
            next_f.rp = (f.rp == AW'(DEPTH - 1)) ? '0 : f.rp + 1'b1;
        end
        next_f.cnt = f.cnt + CW'(push) - CW'(pop);
        next_f.in_ready = next_f.cnt != CW'(DEPTH);
        next_f.out_valid = next_f.cnt != '0;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            f <= F_RST;
        end else begin
            f <= next_f;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[f.wp] <= in_data;
        end
    end

    assign in_ready  = f.in_ready;
    assign out_valid = f.out_valid;
    assign out_data  = mem[f.rp];
endmodule

module ddr3_command_decoder (
    input  wire logic          sys_clk,
    input  wire logic          nrst,
    input  wire logic          ck,
    input  wire logic          cke,
    input  wire logic          cs_n,
    input  wire logic          ras_n,
    input  wire logic          cas_n,
    input  wire logic          we_n,
    input  wire logic [2:0]    ba,
    input  wire logic [12:0]   addr,
    input  wire logic [1:0]    dm,
    input  wire logic [15:0]   dq_in,
    output logic      [15:0]   dq_out,
    output logic               dq_oe,
    input  wire logic [15:0]   rd_data,
    output logic               rd_beat,
    output logic      [2:0]    beat_bank,
    output logic      [12:0]   beat_row,
    output logic      [9:0]    beat_col,
    output logic               cmd_stb,
    output ddr3_cmd_pkg::cmd_t cmd_kind,
    output logic               cmd_err,
    output logic      [7:0]    bank_open,
    output ddr3_cmd_pkg::pwr_t pwr_state,
    output logic               wr_valid,
    input  wire logic          wr_ready,
    output logic      [2:0]    wr_bank,
    output logic      [12:0]   wr_row,
    output logic      [9:0]    wr_col,
    output logic      [1:0]    wr_be,
    output logic      [15:0]   wr_data,
    output logic               wr_overrun,
    output logic               buf_ready
);
    typedef struct packed {
        logic [ddr3_cmd_pkg::IN_W-1:0] s1;
        logic [ddr3_cmd_pkg::IN_W-1:0] s2;
        logic                          ck_d;
        logic                          cke_prev;
        ddr3_cmd_pkg::pwr_t            pwr;
        logic [7:0]                    row_open;
        logic [7:0][12:0]              row;
        logic [3:0][12:0]              mr;
        logic                          bact;
        logic                          brd;
        logic                          bap;
        logic [2:0]                    bbank;
        logic [9:0]                    bcol;
        logic [3:0]                    beat;
        logic [3:0]                    blen;
        ddr3_cmd_pkg::cmd_t            kind;
        logic                          stb;
        logic                          err;
        logic                          rd_beat;
        logic [2:0]                    obank;
        logic [12:0]                   orow;
        logic [9:0]                    ocol;
        logic [15:0]                   dq_out;
        logic                          dq_oe;
        logic                          push;
        logic [1:0]                    wbe;
        logic [15:0]                   wdata;
        logic                          overrun;
    } st_t;

    st_t         s;
    st_t         next_s;
    logic        ck_s;
    logic        cke_s;
    logic        cs_s_n;
    logic        ras_s_n;
    logic        cas_s_n;
    logic        we_s_n;
    logic [2:0]  ba_s;
    logic [12:0] addr_s;
    logic [1:0]  dm_s;
    logic [15:0] dq_s;
    logic [2:0]  op;
    logic        rise;
    logic        fall;
    logic        edg;
    logic        nop_des;
    logic        all_idle;
    logic        cmd_ok;
    logic        a10;
    logic        fifo_ready;
    logic [ddr3_cmd_pkg::BEAT_W-1:0] fifo_out;

    assign {ck_s, cke_s, cs_s_n, ras_s_n, cas_s_n, we_s_n,
            ba_s, addr_s, dm_s, dq_s} = s.s2;
    assign op       = {ras_s_n, cas_s_n, we_s_n};
    assign rise     = ck_s && !s.ck_d;
    assign fall     = !ck_s && s.ck_d;
    assign edg      = rise || fall;
    assign nop_des  = cs_s_n || (op == ddr3_cmd_pkg::OP_NOP);
    assign all_idle = (s.row_open == '0) && !s.bact;
    assign a10      = addr_s[ddr3_cmd_pkg::AP_BIT];
    assign cmd_ok   = rise && (s.pwr == ddr3_cmd_pkg::PWR_ACTIVE)
                      && s.cke_prev && cke_s && !cs_s_n;

    // column of beat i: nibble wrap for sequential, xor for interleave
    function automatic logic [9:0] burst_col(input logic [9:0] st,
                                             input logic [3:0] i,
                                             input logic       il);
        logic [2:0] o;
        o = il ? (st[2:0] ^ i[2:0])
               : {st[2] ^ i[2], st[1:0] + i[1:0]};
        return {st[9:3], o};
    endfunction

    always_comb begin
        ddr3_cmd_pkg::cmd_t k;
        logic               otf;
        k = ddr3_cmd_pkg::CMD_NONE;
        otf = s.mr[0][ddr3_cmd_pkg::MR_BL_LSB +: 2] == ddr3_cmd_pkg::BL_OTF;
        next_s = s;
        next_s.s1 = {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq_in};
        next_s.s2 = s.s1;
        next_s.ck_d = ck_s;
        next_s.stb = 1'b0;
        next_s.err = 1'b0;
        next_s.rd_beat = 1'b0;
        next_s.push = 1'b0;
        if (s.push && !fifo_ready) begin
            next_s.overrun = 1'b1;
        end
        // one beat on every half link clock
        if (edg && s.bact) begin
            next_s.obank = s.bbank;
            next_s.orow = s.row[s.bbank];
            next_s.ocol = burst_col(s.bcol, s.beat,
                                    s.mr[0][ddr3_cmd_pkg::MR_BT_BIT]);
            if (s.brd) begin
                next_s.rd_beat = 1'b1;
                next_s.dq_out = rd_data;
                next_s.dq_oe = 1'b1;
            end else begin
                next_s.push = 1'b1;
                next_s.dq_oe = 1'b0;
                next_s.wbe = ~dm_s;
                next_s.wdata = {dm_s[1] ? 8'h00 : dq_s[15:8],
                                dm_s[0] ? 8'h00 : dq_s[7:0]};
            end
            next_s.beat = s.beat + 4'h1;
            if (s.beat == s.blen - 4'h1) begin
                next_s.bact = 1'b0;
                if (s.bap) begin
                    next_s.row_open[s.bbank] = 1'b0;
                end
            end
        end else if (edg) begin
            next_s.dq_oe = 1'b0;
        end
        if (rise) begin
            next_s.cke_prev = cke_s;
            unique case (s.pwr)
                ddr3_cmd_pkg::PWR_ACTIVE: begin
                    if (s.cke_prev && !cke_s) begin
                        if (!cs_s_n && op == ddr3_cmd_pkg::OP_REF
                            && all_idle) begin
                            next_s.pwr = ddr3_cmd_pkg::PWR_SELF_REFRESH;
                            k = ddr3_cmd_pkg::CMD_SRE;
                        end else if (nop_des) begin
                            next_s.pwr = ddr3_cmd_pkg::PWR_DOWN;
                            k = ddr3_cmd_pkg::CMD_PDE;
                        end else begin
                            next_s.err = 1'b1;
                        end
                    end else if (cmd_ok) begin
                        unique case (op)
                            ddr3_cmd_pkg::OP_ACT: begin
                                if (!s.row_open[ba_s]) begin
                                    next_s.row_open[ba_s] = 1'b1;
                                    next_s.row[ba_s] = addr_s;
                                    k = ddr3_cmd_pkg::CMD_ACT;
                                end else begin
                                    next_s.err = 1'b1;
                                end
                            end
                            ddr3_cmd_pkg::OP_PRE: begin
                                if (a10) begin
                                    next_s.row_open = '0;
                                    k = ddr3_cmd_pkg::CMD_PREA;
                                end else begin
                                    next_s.row_open[ba_s] = 1'b0;
                                    k = ddr3_cmd_pkg::CMD_PRE;
                                end
                            end
                            ddr3_cmd_pkg::OP_WR, ddr3_cmd_pkg::OP_RD: begin
                                if (s.row_open[ba_s]) begin
                                    if (s.bact && s.bap) begin
                                        next_s.row_open[s.bbank] = 1'b0;
                                    end
                                    next_s.bact = 1'b1;
                                    next_s.brd = op == ddr3_cmd_pkg::OP_RD;
                                    next_s.bap = a10;
                                    next_s.bbank = ba_s;
                                    next_s.bcol = addr_s[9:0];
                                    next_s.beat = 4'h0;
                                    next_s.blen = ((otf
                                        && !addr_s[ddr3_cmd_pkg::BC_BIT])
                                        || (!otf && s.mr[0][1:0]
                                        == ddr3_cmd_pkg::BL_FIXED4))
                                        ? ddr3_cmd_pkg::BEATS_BC4
                                        : ddr3_cmd_pkg::BEATS_BL8;
                                    k = next_s.brd ? ddr3_cmd_pkg::CMD_RD
                                                   : ddr3_cmd_pkg::CMD_WR;
                                end else begin
                                    next_s.err = 1'b1;
                                end
                            end
                            ddr3_cmd_pkg::OP_MRS: begin
                                if (all_idle && !ba_s[2]) begin
                                    next_s.mr[ba_s[1:0]] = addr_s;
                                    k = ddr3_cmd_pkg::CMD_MRS;
                                end else begin
                                    next_s.err = 1'b1;
                                end
                            end
                            ddr3_cmd_pkg::OP_REF: begin
                                if (all_idle) begin
                                    k = ddr3_cmd_pkg::CMD_REF;
                                end else begin
                                    next_s.err = 1'b1;
                                end
                            end
                            ddr3_cmd_pkg::OP_ZQ: begin
                                if (all_idle) begin
                                    k = a10 ? ddr3_cmd_pkg::CMD_ZQL
                                            : ddr3_cmd_pkg::CMD_ZQS;
                                end else begin
                                    next_s.err = 1'b1;
                                end
                            end
                            ddr3_cmd_pkg::OP_NOP: begin
                                k = ddr3_cmd_pkg::CMD_NONE;
                            end
                        endcase
                    end
                end
                ddr3_cmd_pkg::PWR_DOWN,
                ddr3_cmd_pkg::PWR_SELF_REFRESH: begin
                    if (!s.cke_prev && cke_s && nop_des) begin
                        next_s.pwr = ddr3_cmd_pkg::PWR_ACTIVE;
                        k = (s.pwr == ddr3_cmd_pkg::PWR_DOWN)
                            ? ddr3_cmd_pkg::CMD_PDX
                            : ddr3_cmd_pkg::CMD_SRX;
                    end
                end
                default: begin
                    next_s.pwr = ddr3_cmd_pkg::PWR_ACTIVE;
                end
            endcase
        end
        if (k != ddr3_cmd_pkg::CMD_NONE) begin
            next_s.kind = k;
            next_s.stb = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    beat_fifo #(
        .WIDTH (ddr3_cmd_pkg::BEAT_W),
        .DEPTH (ddr3_cmd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .in_valid  (s.push),
        .in_ready  (fifo_ready),
        .in_data   ({s.obank, s.orow, s.ocol, s.wbe, s.wdata}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (fifo_out)
    );

    assign {wr_bank, wr_row, wr_col, wr_be, wr_data} = fifo_out;
    assign buf_ready  = fifo_ready;
    assign wr_overrun = s.overrun;
    assign dq_out     = s.dq_out;
    assign dq_oe      = s.dq_oe;
    assign rd_beat    = s.rd_beat;
    assign beat_bank  = s.obank;
    assign beat_row   = s.orow;
    assign beat_col   = s.ocol;
    assign cmd_stb    = s.stb;
    assign cmd_kind   = s.kind;
    assign cmd_err    = s.err;
    assign bank_open  = s.row_open;
    assign pwr_state  = s.pwr;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence pd_enter_s;
        rise && s.pwr == ddr3_cmd_pkg::PWR_ACTIVE && s.cke_prev
            && !cke_s && nop_des;
    endsequence
    sequence wake_s;
        rise && s.pwr != ddr3_cmd_pkg::PWR_ACTIVE && !s.cke_prev
            && cke_s && nop_des;
    endsequence

    act_opens_row_a: assert property (
        cmd_ok && op == ddr3_cmd_pkg::OP_ACT && !s.row_open[ba_s]
        |=> s.row_open[$past(ba_s)] && s.row[$past(ba_s)] == $past(addr_s))
        else $error("activate did not open the row");
    pre_all_a: assert property (
        cmd_ok && op == ddr3_cmd_pkg::OP_PRE && a10 |=> s.row_open == '0)
        else $error("precharge all left a bank open");
    closed_bank_a: assert property (
        cmd_ok && (op == ddr3_cmd_pkg::OP_RD || op == ddr3_cmd_pkg::OP_WR)
        && !s.row_open[ba_s] |=> s.err && !s.stb)
        else $error("column command to closed bank accepted");
    chop_len_a: assert property (
        cmd_ok && (op == ddr3_cmd_pkg::OP_RD || op == ddr3_cmd_pkg::OP_WR)
        && s.row_open[ba_s]
        && s.mr[0][1:0] == ddr3_cmd_pkg::BL_OTF && !addr_s[12]
        |=> s.blen == ddr3_cmd_pkg::BEATS_BC4 && s.bact)
        else $error("chopped burst length wrong");
    first_col_a: assert property (
        s.bact && edg && s.beat == 4'h0 |=> s.ocol == $past(s.bcol))
        else $error("burst did not start at command column");
    auto_pre_a: assert property (
        s.bact && edg && s.bap && s.beat == s.blen - 4'h1 && !cmd_ok
        |=> !s.row_open[$past(s.bbank)] && !s.bact)
        else $error("auto precharge missing after burst");
    mask_lanes_a: assert property (
        s.push |-> (s.wbe[0] || s.wdata[7:0] == 8'h00)
        && (s.wbe[1] || s.wdata[15:8] == 8'h00))
        else $error("masked byte lane carried data");
    beat_on_edge_a: assert property (
        $rose(s.push || s.rd_beat) |-> $past(edg) ##1 !(s.push || s.rd_beat))
        else $error("beat not tied to a half clock");
    pd_entry_a: assert property (
        pd_enter_s |=> s.pwr == ddr3_cmd_pkg::PWR_DOWN
        && s.kind == ddr3_cmd_pkg::CMD_PDE)
        else $error("power-down not entered");
    pd_exit_a: assert property (
        wake_s |=> s.pwr == ddr3_cmd_pkg::PWR_ACTIVE && s.stb)
        else $error("power-down or self-refresh not left");
    mrs_load_a: assert property (
        cmd_ok && op == ddr3_cmd_pkg::OP_MRS && all_idle && !ba_s[2]
        |=> s.mr[$past(ba_s[1:0])] == $past(addr_s))
        else $error("mode register not loaded");
endmodule

// [verification/ddr3_ctrl_model.sv]
// memory controller model that drives the command and data pins
`timescale 1ns/1ps

module ddr3_ctrl_model (
    input  wire logic        sys_clk,
    output logic             ck,
    output logic             cke,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic      [2:0]  ba,
    output logic      [12:0] addr,
    output logic      [1:0]  dm,
    output logic      [15:0] dq_in
);
    initial begin
        ck = 1'b0;
        forever #32 ck = ~ck;
    end
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h0F;
        ba = 3'h0;
        addr = 13'h0000;
        dm = 2'h1;
        dq_in = 16'h5A3C;
    end
    // one command on a link rise, then deselect until the burst is over
    task issue(input logic [2:0] op, input logic [2:0] b,
               input logic [12:0] a, input logic ke);
        @(negedge ck);
        @(posedge sys_clk);
        #1;
        cke = ke;
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = op;
        ba = b;
        addr = a;
        dq_in = (op == ddr3_cmd_pkg::OP_WR) ? 16'hA5C3 : 16'h5A3C;
        @(negedge ck);
        @(posedge sys_clk);
        #1;
        cs_n = 1'b1;
        ba = ~b;
        addr = ~a;
        repeat (5) @(negedge ck);
        @(posedge sys_clk);
        #1;
        dq_in = 16'h5A3C;
    endtask
endmodule

// [verification/tb_top.sv]
// self-checking bench for the command decoder and its write buffer
`timescale 1ns/1ps

module tb_top;
    logic               sys_clk, nrst, ck, cke, cs_n, ras_n, cas_n, we_n;
    logic        [2:0]  ba, wr_bank, f_bank, beat_bank, r_bank;
    logic        [12:0] addr, wr_row, f_row, beat_row, r_row;
    logic        [1:0]  dm, wr_be, f_be;
    logic        [15:0] dq_in, rd_data, wr_data, f_data, dq_out, r_dq;
    logic        [9:0]  wr_col, f_col, beat_col, r_col;
    logic        [7:0]  bank_open;
    logic               rd_beat, cmd_err, wr_valid, wr_ready, cmd_stb;
    logic               wr_overrun, buf_ready, dq_oe, r_oe;
    int                 n_stb;
    ddr3_cmd_pkg::cmd_t cmd_kind;
    ddr3_cmd_pkg::pwr_t pwr_state;
    int                 failures, samples_checked, n_err, n_rd, n_pop, cyc;

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    ddr3_ctrl_model ctl_u (.sys_clk(sys_clk), .ck(ck), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
        .addr(addr), .dm(dm), .dq_in(dq_in));
    ddr3_command_decoder dut_u (.sys_clk(sys_clk), .nrst(nrst), .ck(ck),
        .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .ba(ba), .addr(addr), .dm(dm), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .rd_data(rd_data), .rd_beat(rd_beat),
        .beat_bank(beat_bank), .beat_row(beat_row), .beat_col(beat_col),
        .cmd_stb(cmd_stb), .cmd_kind(cmd_kind), .cmd_err(cmd_err),
        .bank_open(bank_open), .pwr_state(pwr_state), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_bank(wr_bank), .wr_row(wr_row),
        .wr_col(wr_col),
        .wr_be(wr_be), .wr_data(wr_data), .wr_overrun(wr_overrun),
        .buf_ready(buf_ready));

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (rd_beat) begin
            n_rd <= n_rd + 1;
            rd_data <= rd_data + 16'h0001;
            {r_oe, r_bank, r_row, r_col, r_dq} <=
                {dq_oe, beat_bank, beat_row, beat_col, dq_out};
        end
        if (cmd_err)
            n_err <= n_err + 1;
        if (cmd_stb)
            n_stb <= n_stb + 1;
        if (wr_valid && wr_ready) begin
            if (n_pop == 0)
                {f_bank, f_row, f_col, f_be, f_data} <=
                    {wr_bank, wr_row, wr_col, wr_be, wr_data};
            n_pop <= n_pop + 1;
        end
        if (cyc == 20000) begin
            failures = failures + 1;
            print_verdict();
        end
    end

    task check(input string what, input logic [15:0] exp,
               input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task clr(input string name);
        $display("test %s done", name);
        n_err = 0;
        n_stb = 0;
        n_rd = 0;
        n_pop = 0;
    endtask
    task print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        wr_ready = 1'b1;
        rd_data = 16'h1000;
        failures = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (3) @(posedge sys_clk);
        #1 nrst = 1'b1;
        mode_test();
        bank_test();
        write_test();
        read_test();
        power_test();
        reset_test();
        print_verdict();
    end
    task mode_test;
        ctl_u.issue(ddr3_cmd_pkg::OP_NOP, 3'h0, 13'h0000, 1'b1);
        ctl_u.issue(ddr3_cmd_pkg::OP_MRS, 3'h2, 13'h0000, 1'b1);
        check("kind", ddr3_cmd_pkg::CMD_MRS, cmd_kind);
        ctl_u.issue(ddr3_cmd_pkg::OP_MRS, 3'h0, 13'h0001, 1'b1);
        ctl_u.issue(ddr3_cmd_pkg::OP_MRS, 3'h4, 13'h0000, 1'b1);
        check("err", 1, n_err);
        check("stb", 2, n_stb);
        clr("mode");
    endtask
    task bank_test;
        ctl_u.issue(ddr3_cmd_pkg::OP_ACT, 3'h3, 13'h0155, 1'b1);
        check("open", 8'h08, bank_open);
        ctl_u.issue(ddr3_cmd_pkg::OP_ACT, 3'h3, 13'h0155, 1'b1);
        ctl_u.issue(ddr3_cmd_pkg::OP_RD, 3'h5, 13'h0000, 1'b1);
        check("err", 2, n_err);
        ctl_u.issue(ddr3_cmd_pkg::OP_ACT, 3'h6, 13'h0001, 1'b1);
        ctl_u.issue(ddr3_cmd_pkg::OP_PRE, 3'h3, 13'h0000, 1'b1);
        check("open", 8'h40, bank_open);
        ctl_u.issue(ddr3_cmd_pkg::OP_PRE, 3'h0, 13'h0400, 1'b1);
        check("open", 8'h00, bank_open);
        clr("bank");
    endtask
    task write_test;
        ctl_u.issue(ddr3_cmd_pkg::OP_ACT, 3'h3, 13'h0155, 1'b1);
        wr_ready = 1'b0;
        ctl_u.issue(ddr3_cmd_pkg::OP_WR, 3'h3, 13'h0004, 1'b1);
        ctl_u.issue(ddr3_cmd_pkg::OP_WR, 3'h3, 13'h1008, 1'b1);
        ctl_u.issue(ddr3_cmd_pkg::OP_WR, 3'h3, 13'h0000, 1'b1);
        check("buf_ready", 0, buf_ready);
        check("overrun", 0, wr_overrun);
        check("pops", 0, n_pop);
        @(posedge sys_clk);
        #1 wr_ready = 1'b1;
        repeat (40) @(posedge sys_clk);
        check("pops", 16, n_pop);
        check("col", 10'h004, f_col);
        check("be", 2'h2, f_be);
        check("data", 16'hA500, f_data);
        check("bank", 3'h3, f_bank);
        check("row", 13'h0155, f_row);
        clr("write");
    endtask
    task read_test;
        ctl_u.issue(ddr3_cmd_pkg::OP_RD, 3'h3, 13'h1408, 1'b1);
        check("beats", 8, n_rd);
        check("open", 8'h00, bank_open);
        check("col", 10'h00F, r_col);
        check("rdata", 16'h1007, r_dq);
        check("oe", 1, r_oe);
        check("oe", 0, dq_oe);
        check("bank", 3'h3, r_bank);
        check("row", 13'h0155, r_row);
        ctl_u.issue(ddr3_cmd_pkg::OP_MRS, 3'h0, 13'h000A, 1'b1);
        ctl_u.issue(ddr3_cmd_pkg::OP_ACT, 3'h3, 13'h0155, 1'b1);
        ctl_u.issue(ddr3_cmd_pkg::OP_RD, 3'h3, 13'h140D, 1'b1);
        check("beats", 12, n_rd);
        check("col", 10'h00E, r_col);
        clr("read");
    endtask
    task power_test;
        ctl_u.issue(ddr3_cmd_pkg::OP_REF, 3'h0, 13'h0000, 1'b1);
        check("kind", ddr3_cmd_pkg::CMD_REF, cmd_kind);
        ctl_u.issue(ddr3_cmd_pkg::OP_ZQ, 3'h0, 13'h0400, 1'b1);
        check("kind", ddr3_cmd_pkg::CMD_ZQL, cmd_kind);
        ctl_u.issue(ddr3_cmd_pkg::OP_ZQ, 3'h0, 13'h0000, 1'b1);
        check("kind", ddr3_cmd_pkg::CMD_ZQS, cmd_kind);
        ctl_u.issue(ddr3_cmd_pkg::OP_REF, 3'h0, 13'h0000, 1'b0);
        check("pwr", ddr3_cmd_pkg::PWR_SELF_REFRESH, pwr_state);
        ctl_u.issue(ddr3_cmd_pkg::OP_NOP, 3'h0, 13'h0000, 1'b1);
        check("pwr", ddr3_cmd_pkg::PWR_ACTIVE, pwr_state);
        ctl_u.issue(ddr3_cmd_pkg::OP_NOP, 3'h0, 13'h0000, 1'b0);
        check("pwr", ddr3_cmd_pkg::PWR_DOWN, pwr_state);
        ctl_u.issue(ddr3_cmd_pkg::OP_NOP, 3'h0, 13'h0000, 1'b1);
        check("pwr", ddr3_cmd_pkg::PWR_ACTIVE, pwr_state);
        clr("power");
    endtask
    task reset_test;
        @(posedge sys_clk);
        #1 nrst = 1'b0;
        @(posedge sys_clk);
        #1 nrst = 1'b1;
        check("kind", ddr3_cmd_pkg::CMD_NONE, cmd_kind);
        ctl_u.issue(ddr3_cmd_pkg::OP_NOP, 3'h0, 13'h0000, 1'b1);
        ctl_u.issue(ddr3_cmd_pkg::OP_ACT, 3'h1, 13'h0002, 1'b1);
        check("open", 8'h02, bank_open);
        clr("reset");
    endtask
endmodule
